// ===== rtl/vaopcr_top.v
// Purpose: APB register bank for channel offsets, offset DAC codes, filter and PLL line settings.
// Assumes: Sync and clamp pins are asynchronous; lineSyncSelect comes from logic on clk.
// Notes:   One wait state on every APB access; unmapped addresses answer with pslverr.
// Function
// - Compensation on: offset acts as digital offset.
// - Compensation off: offset drives DAC upper bits.
// - Codes 0x00/0x80/0xFF map min, mid, max.
// - DAC config bit 0 selects half/quarter range.
// - DAC low bits from config bits per channel.
// - Bandwidth field bits 3:1 sets filter corner.
// - Peaking field bits 7:4, keep at most two.
// - Line total: six high bits, eight low.
// - Line total reaches PLL on low write only.
// - Six-bit sample phase in 5.625 degree steps.
// - Coast programmed lines before frame sync start.
// - Coast programmed lines after frame sync end.
// - Bit 0 picks lock edge, input one.
// - Bit 1 picks lock edge, input two.
// - Compensation on at reset; disable bit turns off.
// - Offsets reach DACs at clamp, 100ms latest.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "vaopcr_defs.vh"
module vaopcr_top #(
  parameter ADDR_W             = 8,
  parameter LINE_W             = 12,
  parameter TIMER_W            = 23,
  parameter CLAMP_WAIT_CYCLES  = `VAOPCR_CLAMP_WAIT_CYCLES
) (
  clk,
  nrst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  lineSyncInputOne,
  lineSyncInputTwo,
  lineSyncSelect,
  frameSyncIn,
  clampIn,
  digitalOffset,
  offsetDacCode,
  offsetDacRangeQuarter,
  frontEndBandwidth,
  peakingCode,
  lineTotal,
  lineTotalLoad,
  samplePhase,
  pllCoast,
  pllLockPulse,
  autoBlackLevelCompOn
);
  input  wire              clk;
  input  wire              nrst;
  input  wire              psel;
  input  wire              penable;
  input  wire              pwrite;
  input  wire [ADDR_W-1:0] paddr;
  input  wire [31:0]       pwdata;
  output reg  [31:0]       prdata;
  output reg               pready;
  output reg               pslverr;
  input  wire              lineSyncInputOne;
  input  wire              lineSyncInputTwo;
  input  wire              lineSyncSelect;
  input  wire              frameSyncIn;
  input  wire              clampIn;
  output wire [23:0]       digitalOffset;
  output wire [29:0]       offsetDacCode;
  output reg               offsetDacRangeQuarter;
  output reg  [2:0]        frontEndBandwidth;
  output reg  [3:0]        peakingCode;
  output reg  [13:0]       lineTotal;
  output reg               lineTotalLoad;
  output reg  [5:0]        samplePhase;
  output reg               pllCoast;
  output reg               pllLockPulse;
  output reg               autoBlackLevelCompOn;

  localparam integer       WAIT_LAST_INT = CLAMP_WAIT_CYCLES - 1;
  localparam [TIMER_W-1:0] WAIT_LAST     = WAIT_LAST_INT[TIMER_W-1:0];
  localparam [LINE_W-1:0]  LINE_MAX      = {LINE_W{1'b1}};
  localparam [7:0]         RST_BW        = `VAOPCR_RST_BANDWIDTH;
  localparam [7:0]         RST_DAC       = `VAOPCR_RST_DAC_CFG;

  reg  [7:0]         redOffsetReg;
  reg  [7:0]         greenOffsetReg;
  reg  [7:0]         blueOffsetReg;
  reg  [7:0]         dacCfgReg;
  reg  [7:0]         bandwidthReg;
  reg  [5:0]         totalHighReg;
  reg  [7:0]         totalLowReg;
  reg  [5:0]         phaseReg;
  reg  [7:0]         preCoastReg;
  reg  [7:0]         postCoastReg;
  reg  [7:0]         lockEdgeReg;
  reg  [7:0]         blackCfgReg;
  reg  [23:0]        appliedOffsetReg;
  reg  [5:0]         appliedLsbReg;
  reg  [TIMER_W-1:0] waitCountReg;
  reg                pendingReg;
  reg  [LINE_W-1:0]  linesSinceReg;
  reg  [LINE_W-1:0]  frameLinesReg;
  reg  [7:0]         postLeftReg;
  reg  [31:0]        readNext;
  reg                errNext;

  wire [5:0]  regIdx;
  wire        alignedHit;
  wire        accessDone;
  wire        writeDone;
  wire        offsetWrite;
  wire        applyNow;
  wire [3:0]  syncLevel;
  wire [3:0]  syncRise;
  wire [3:0]  syncFall;
  wire [3:0]  syncPins;
  wire        edgeOne;
  wire        edgeTwo;
  wire        lineEdge;
  wire        preCoastHit;
  wire        coastNow;
  wire [23:0] offsetBus;

  assign regIdx     = paddr[7:2];
  assign alignedHit = (paddr[1:0] == 2'b00);
  assign accessDone = psel & penable & pready;
  assign writeDone  = accessDone & pwrite & ~pslverr;
  assign syncPins   = {clampIn, frameSyncIn, lineSyncInputTwo, lineSyncInputOne};
  assign offsetBus  = {blueOffsetReg, greenOffsetReg, redOffsetReg};

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gSync
      vaopcr_sync uSync (
        .clk   (clk),
        .nrst  (nrst),
        .pinIn (syncPins[i]),
        .level (syncLevel[i]),
        .rise  (syncRise[i]),
        .fall  (syncFall[i])
      );
    end
  endgenerate

  // Read decode and error answer for unmapped words.
  always @* begin
    readNext = 32'h0000_0000;
    errNext  = 1'b0;
    if (!alignedHit) begin
      errNext = 1'b1;
    end else begin
      case (regIdx)
        `VAOPCR_IDX_RED_OFS:    readNext[7:0] = redOffsetReg;
        `VAOPCR_IDX_GREEN_OFS:  readNext[7:0] = greenOffsetReg;
        `VAOPCR_IDX_BLUE_OFS:   readNext[7:0] = blueOffsetReg;
        `VAOPCR_IDX_DAC_CFG:    readNext[7:0] = dacCfgReg;
        `VAOPCR_IDX_BANDWIDTH:  readNext[7:0] = bandwidthReg;
        `VAOPCR_IDX_TOTAL_HIGH: readNext[5:0] = totalHighReg;
        `VAOPCR_IDX_TOTAL_LOW:  readNext[7:0] = totalLowReg;
        `VAOPCR_IDX_PHASE:      readNext[5:0] = phaseReg;
        `VAOPCR_IDX_PRE_COAST:  readNext[7:0] = preCoastReg;
        `VAOPCR_IDX_POST_COAST: readNext[7:0] = postCoastReg;
        `VAOPCR_IDX_LOCK_EDGE:  readNext[7:0] = lockEdgeReg;
        `VAOPCR_IDX_BLACK_CFG:  readNext[7:0] = blackCfgReg;
        default:                errNext = 1'b1;
      endcase
    end
  end

  // The answer comes one cycle into the access phase.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel & penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= errNext;
      prdata  <= pwrite ? 32'h0000_0000 : readNext;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes; reserved bits of the eight-bit registers are stored as written, the six-bit registers drop bits 7:6.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      redOffsetReg   <= `VAOPCR_RST_OFFSET;
      greenOffsetReg <= `VAOPCR_RST_OFFSET;
      blueOffsetReg  <= `VAOPCR_RST_OFFSET;
      dacCfgReg      <= `VAOPCR_RST_DAC_CFG;
      bandwidthReg   <= `VAOPCR_RST_BANDWIDTH;
      totalHighReg   <= `VAOPCR_RST_TOTAL_HIGH;
      totalLowReg    <= `VAOPCR_RST_TOTAL_LOW;
      phaseReg       <= `VAOPCR_RST_PHASE;
      preCoastReg    <= `VAOPCR_RST_PRE_COAST;
      postCoastReg   <= `VAOPCR_RST_POST_COAST;
      lockEdgeReg    <= `VAOPCR_RST_LOCK_EDGE;
      blackCfgReg    <= `VAOPCR_RST_BLACK_CFG;
    end else if (writeDone) begin
      case (regIdx)
        `VAOPCR_IDX_RED_OFS:    redOffsetReg   <= pwdata[7:0];
        `VAOPCR_IDX_GREEN_OFS:  greenOffsetReg <= pwdata[7:0];
        `VAOPCR_IDX_BLUE_OFS:   blueOffsetReg  <= pwdata[7:0];
        `VAOPCR_IDX_DAC_CFG:    dacCfgReg      <= pwdata[7:0];
        `VAOPCR_IDX_BANDWIDTH:  bandwidthReg   <= pwdata[7:0];
        `VAOPCR_IDX_TOTAL_HIGH: totalHighReg   <= pwdata[5:0];
        `VAOPCR_IDX_TOTAL_LOW:  totalLowReg    <= pwdata[7:0];
        `VAOPCR_IDX_PHASE:      phaseReg       <= pwdata[5:0];
        `VAOPCR_IDX_PRE_COAST:  preCoastReg    <= pwdata[7:0];
        `VAOPCR_IDX_POST_COAST: postCoastReg   <= pwdata[7:0];
        `VAOPCR_IDX_LOCK_EDGE:  lockEdgeReg    <= pwdata[7:0];
        `VAOPCR_IDX_BLACK_CFG:  blackCfgReg    <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lineTotal     <= {`VAOPCR_RST_TOTAL_HIGH, `VAOPCR_RST_TOTAL_LOW};
      lineTotalLoad <= 1'b0;
    end else begin
      lineTotalLoad <= writeDone & (regIdx == `VAOPCR_IDX_TOTAL_LOW);
      if (writeDone & (regIdx == `VAOPCR_IDX_TOTAL_LOW)) begin
        lineTotal <= {totalHighReg, pwdata[7:0]};
      end
    end
  end

  // Plain setting outputs.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frontEndBandwidth    <= RST_BW[`VAOPCR_BW_HI:`VAOPCR_BW_LO];
      peakingCode          <= RST_BW[`VAOPCR_PEAK_HI:`VAOPCR_PEAK_LO];
      samplePhase          <= `VAOPCR_RST_PHASE;
      autoBlackLevelCompOn <= 1'b1;
    end else begin
      frontEndBandwidth    <= bandwidthReg[`VAOPCR_BW_HI:`VAOPCR_BW_LO];
      peakingCode          <= bandwidthReg[`VAOPCR_PEAK_HI:`VAOPCR_PEAK_LO];
      samplePhase          <= phaseReg;
      autoBlackLevelCompOn <= ~blackCfgReg[`VAOPCR_BLACK_OFF_BIT];
    end
  end

  assign offsetWrite = writeDone & (regIdx >= `VAOPCR_IDX_RED_OFS) & (regIdx <= `VAOPCR_IDX_DAC_CFG);
  assign applyNow    = pendingReg & (syncRise[3] | (waitCountReg == WAIT_LAST));

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendingReg            <= 1'b0;
      waitCountReg          <= {TIMER_W{1'b0}};
      appliedOffsetReg      <= {3{`VAOPCR_RST_OFFSET}};
      appliedLsbReg         <= RST_DAC[`VAOPCR_DAC_LSB_HI:`VAOPCR_DAC_LSB_LO];
      offsetDacRangeQuarter <= 1'b0;
    end else begin
      pendingReg <= offsetWrite | (pendingReg & ~applyNow);
      if (offsetWrite | applyNow | ~pendingReg) begin
        waitCountReg <= {TIMER_W{1'b0}};
      end else begin
        waitCountReg <= waitCountReg + {{(TIMER_W-1){1'b0}}, 1'b1};
      end
      if (applyNow) begin
        appliedOffsetReg      <= offsetBus;
        appliedLsbReg         <= dacCfgReg[`VAOPCR_DAC_LSB_HI:`VAOPCR_DAC_LSB_LO];
        offsetDacRangeQuarter <= dacCfgReg[`VAOPCR_DAC_RANGE_BIT];
      end
    end
  end

  generate
    for (i = 0; i < 3; i = i + 1) begin : gChan
      reg [7:0] digitalReg;
      reg [9:0] dacReg;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          digitalReg <= 8'h00;
          dacReg     <= `VAOPCR_DAC_MID;
        end else if (autoBlackLevelCompOn) begin
          digitalReg <= appliedOffsetReg[8*i+7:8*i] ^ `VAOPCR_OFFSET_MID;
          dacReg     <= `VAOPCR_DAC_MID;
        end else begin
          digitalReg <= 8'h00;
          dacReg     <= {appliedOffsetReg[8*i+7:8*i], appliedLsbReg[2*i+1:2*i]};
        end
      end
      assign digitalOffset[8*i+7:8*i] = digitalReg;
      assign offsetDacCode[10*i+9:10*i] = dacReg;
    end
  endgenerate

  assign edgeOne  = lockEdgeReg[`VAOPCR_EDGE_ONE_BIT] ? syncRise[0] : syncFall[0];
  assign edgeTwo  = lockEdgeReg[`VAOPCR_EDGE_TWO_BIT] ? syncRise[1] : syncFall[1];
  assign lineEdge = lineSyncSelect ? edgeTwo : edgeOne;

  assign preCoastHit = (frameLinesReg != {LINE_W{1'b0}}) &
                       (({1'b0, linesSinceReg} + {{(LINE_W-7){1'b0}}, preCoastReg}) >= {1'b0, frameLinesReg});
  // Coast window: frame sync level, pre coast lines and post coast lines
  // The fall cycle itself coasts, so no gap opens before the post counter loads.
  assign coastNow    = syncLevel[2] | (syncFall[2] & (postCoastReg != 8'h00)) | preCoastHit |
                       (postLeftReg != 8'h00);

  // Lines are counted between frame sync starts to predict the next one.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linesSinceReg <= {LINE_W{1'b0}};
      frameLinesReg <= {LINE_W{1'b0}};
      postLeftReg   <= 8'h00;
      pllCoast      <= 1'b0;
      pllLockPulse  <= 1'b0;
    end else begin
      if (syncRise[2]) begin
        frameLinesReg <= linesSinceReg;
        linesSinceReg <= {LINE_W{1'b0}};
      end else if (lineEdge & (linesSinceReg != LINE_MAX)) begin
        linesSinceReg <= linesSinceReg + {{(LINE_W-1){1'b0}}, 1'b1};
      end
      if (syncFall[2]) begin
        postLeftReg <= postCoastReg;
      end else if (lineEdge & (postLeftReg != 8'h00)) begin
        postLeftReg <= postLeftReg - 8'h01;
      end
      pllCoast     <= coastNow;
      pllLockPulse <= lineEdge & ~coastNow;
    end
  end
endmodule

// ===== rtl/vaopcr_defs.vh
// Purpose: Offsets, field positions, reset values and timing for the offset and PLL configuration bank.
// Assumes: Register indexes are word indexes; the APB byte address is four times the index.
// Notes:   Included by bare name from the top module only.
`ifndef VAOPCR_DEFS_VH
`define VAOPCR_DEFS_VH

// Register indexes.
`define VAOPCR_IDX_RED_OFS       6'h09
`define VAOPCR_IDX_GREEN_OFS     6'h0a
`define VAOPCR_IDX_BLUE_OFS      6'h0b
`define VAOPCR_IDX_DAC_CFG       6'h0c
`define VAOPCR_IDX_BANDWIDTH     6'h0d
`define VAOPCR_IDX_TOTAL_HIGH    6'h0e
`define VAOPCR_IDX_TOTAL_LOW     6'h0f
`define VAOPCR_IDX_PHASE         6'h10
`define VAOPCR_IDX_PRE_COAST     6'h11
`define VAOPCR_IDX_POST_COAST    6'h12
`define VAOPCR_IDX_LOCK_EDGE     6'h13
`define VAOPCR_IDX_BLACK_CFG     6'h17

// Reset values.
`define VAOPCR_RST_OFFSET        8'h80
`define VAOPCR_RST_DAC_CFG       8'h00
`define VAOPCR_RST_BANDWIDTH     8'h2e
`define VAOPCR_RST_TOTAL_HIGH    6'h03
`define VAOPCR_RST_TOTAL_LOW     8'h20
`define VAOPCR_RST_PHASE         6'h00
`define VAOPCR_RST_PRE_COAST     8'h04
`define VAOPCR_RST_POST_COAST    8'h04
`define VAOPCR_RST_LOCK_EDGE     8'h04
`define VAOPCR_RST_BLACK_CFG     8'h40

// Field positions.
`define VAOPCR_DAC_RANGE_BIT     0
`define VAOPCR_DAC_LSB_LO        2
`define VAOPCR_DAC_LSB_HI        7
`define VAOPCR_BW_LO             1
`define VAOPCR_BW_HI             3
`define VAOPCR_PEAK_LO           4
`define VAOPCR_PEAK_HI           7
`define VAOPCR_EDGE_ONE_BIT      0
`define VAOPCR_EDGE_TWO_BIT      1
`define VAOPCR_BLACK_OFF_BIT     0

// Offset code meaning zero digital offset and the DAC midpoint.
`define VAOPCR_OFFSET_MID        8'h80
`define VAOPCR_DAC_MID           10'h200

// Clock rate and the longest wait for a clamp before offsets are forced through.
`define VAOPCR_CLK_HZ            40000000
`define VAOPCR_CLAMP_WAIT_MS     100
`define VAOPCR_CLAMP_WAIT_CYCLES (`VAOPCR_CLAMP_WAIT_MS * (`VAOPCR_CLK_HZ / 1000))

`endif

// ===== rtl/vaopcr_sync.v
// Purpose: Two-stage synchroniser for one pin with edge pulses.
// Assumes: The pin is asynchronous to clk.
// Notes:   Edges are taken between the second and third stages only.
`timescale 1ns/1ps
module vaopcr_sync (
  clk,
  nrst,
  pinIn,
  level,
  rise,
  fall
);
  input  wire clk;
  input  wire nrst;
  input  wire pinIn;
  output wire level;
  output wire rise;
  output wire fall;

  reg stageOneReg;
  reg stageTwoReg;
  reg stageThreeReg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stageOneReg   <= 1'b0;
      stageTwoReg   <= 1'b0;
      stageThreeReg <= 1'b0;
    end else begin
      stageOneReg   <= pinIn;
      stageTwoReg   <= stageOneReg;
      stageThreeReg <= stageTwoReg;
    end
  end

  assign level = stageTwoReg;
  assign rise  = stageTwoReg & ~stageThreeReg;
  assign fall  = ~stageTwoReg & stageThreeReg;
endmodule

// ===== bench/vaopcr_props.sv
// Purpose: Timing relations of the offset and PLL configuration bank.
// Assumes: Sees only top ports; one clock domain.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module vaopcr_props (
  input logic        clk,
  input logic        nrst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic        pready,
  input logic        pslverr,
  input logic [23:0] digitalOffset,
  input logic [29:0] offsetDacCode,
  input logic [13:0] lineTotal,
  input logic        lineTotalLoad,
  input logic        frameSyncIn,
  input logic        pllCoast,
  input logic        pllLockPulse,
  input logic        autoBlackLevelCompOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire done = psel && penable && pready;
  sequence s_setup; psel && !penable; endsequence
  sequence s_frame; frameSyncIn[*5] ##1 !frameSyncIn; endsequence
  property p_answer; s_setup ##1 penable |-> !pready ##1 pready; endproperty
  a_answer: assert property (p_answer) else $error("ready not in second access cycle");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmapped; done && paddr == 8'hFC |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_load; done && pwrite && paddr == 8'h3C |-> ##[1:2] lineTotalLoad; endproperty
  a_load: assert property (p_load) else $error("low write did not load total");
  property p_high; done && pwrite && paddr == 8'h38 |=> (!lineTotalLoad)[*2]; endproperty
  a_high: assert property (p_high) else $error("high write loaded total");
  property p_stable; !$stable(lineTotal) |-> lineTotalLoad; endproperty
  a_stable: assert property (p_stable) else $error("total changed without load");
  property p_comp_on; autoBlackLevelCompOn[*3] |-> offsetDacCode == 30'h2008_0200; endproperty
  a_comp_on: assert property (p_comp_on) else $error("dac not at midpoint");
  property p_comp_off; (!autoBlackLevelCompOn)[*3] |-> digitalOffset == 24'h0; endproperty
  a_comp_off: assert property (p_comp_off) else $error("digital offset in analog mode");
  property p_coast; s_frame |-> pllCoast[*3]; endproperty
  a_coast: assert property (p_coast) else $error("no coast around frame sync");
  property p_lock; pllLockPulse |=> !pllLockPulse; endproperty
  a_lock: assert property (p_lock) else $error("lock pulse too long");
endmodule
bind vaopcr_top vaopcr_props vaopcr_props_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .digitalOffset(digitalOffset),
  .offsetDacCode(offsetDacCode), .lineTotal(lineTotal), .lineTotalLoad(lineTotalLoad),
  .frameSyncIn(frameSyncIn), .pllCoast(pllCoast), .pllLockPulse(pllLockPulse),
  .autoBlackLevelCompOn(autoBlackLevelCompOn));

// ===== bench/tb.sv
// Purpose: Self-checking bench for the offset and PLL configuration bank.
// Assumes: APB master driven on rising edges; short clamp wait.
// Notes:   Sync pins pulsed for six cycles per level.
`timescale 1ns/1ps
module tb;
  localparam int WAIT_CYC = 50;
  logic clk, nrst, psel, penable, pwrite, errBit, lineSyncSelect, frameSyncIn, clampIn;
  logic lineSyncInputOne, lineSyncInputTwo, pready, pslverr, offsetDacRangeQuarter;
  logic lineTotalLoad, pllCoast, pllLockPulse, autoBlackLevelCompOn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [23:0] digitalOffset;
  logic [29:0] offsetDacCode;
  logic [2:0]  frontEndBandwidth;
  logic [3:0]  peakingCode;
  logic [13:0] lineTotal;
  logic [5:0]  samplePhase;
  logic [7:0]  ra [12] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h5C};
  logic [7:0]  rv [12] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h2E, 8'h03, 8'h20, 8'h00, 8'h04, 8'h04, 8'h04, 8'h40};
  int          bad_count, check_count, loads, locks, r, f;
  vaopcr_top #(.CLAMP_WAIT_CYCLES(WAIT_CYC)) vaopcr_top_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lineSyncInputOne(lineSyncInputOne), .lineSyncInputTwo(lineSyncInputTwo),
    .lineSyncSelect(lineSyncSelect), .frameSyncIn(frameSyncIn), .clampIn(clampIn),
    .digitalOffset(digitalOffset), .offsetDacCode(offsetDacCode), .offsetDacRangeQuarter(offsetDacRangeQuarter),
    .frontEndBandwidth(frontEndBandwidth), .peakingCode(peakingCode), .lineTotal(lineTotal),
    .lineTotalLoad(lineTotalLoad), .samplePhase(samplePhase), .pllCoast(pllCoast),
    .pllLockPulse(pllLockPulse), .autoBlackLevelCompOn(autoBlackLevelCompOn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (lineTotalLoad === 1'b1) loads++;
    if (pllLockPulse === 1'b1) locks++;
  end
  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e, input string m);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    chk(pready, 1, "no ready");
    rdat = prdata; errBit = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdat, {24'h0, e}, "read");
  endtask
  task sync(input logic two);
    int l0;
    l0 = locks;
    if (two) lineSyncInputTwo <= 1'b1; else lineSyncInputOne <= 1'b1;
    cyc(6);
    r = locks - l0;
    l0 = locks;
    lineSyncInputOne <= 1'b0; lineSyncInputTwo <= 1'b0;
    cyc(6);
    f = locks - l0;
  endtask
  task t_reset;
    for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
    chk({lineTotal, frontEndBandwidth, peakingCode, autoBlackLevelCompOn}, {14'h0320, 3'h7, 4'h2, 1'b1}, "rst");
    xfer(1'b0, 8'hFC, 8'h00);
    chk({errBit, rdat}, {1'b1, 32'h0}, "unmapped");
    xfer(1'b1, 8'h25, 8'h00);
    chk(errBit, 1, "misaligned");
    rd(8'h24, 8'h80);
  endtask
  task t_total;
    xfer(1'b1, 8'h38, 8'h12);
    cyc(2);
    chk(lineTotal, 14'h0320, "high only");
    rd(8'h38, 8'h12);
    xfer(1'b1, 8'h3C, 8'h34);
    cyc(2);
    chk({loads, lineTotal}, {32'd1, 14'h1234}, "total");
  endtask
  task t_bw;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'h34, {i[3:0], 3'(i * 3), 1'b1});
      cyc(2);
      chk({peakingCode, frontEndBandwidth}, {i[3:0], 3'(i * 3)}, "bw");
    end
    xfer(1'b1, 8'h40, 8'hFF);
    cyc(2);
    chk(samplePhase, 6'h3F, "phase");
    rd(8'h40, 8'h3F);
  endtask
  task t_offset;
    xfer(1'b1, 8'h24, 8'h00);
    xfer(1'b1, 8'h28, 8'hFF);
    xfer(1'b1, 8'h2C, 8'h81);
    cyc(1);
    chk(digitalOffset, 24'h0, "early");
    clampIn <= 1'b1;
    cyc(6);
    clampIn <= 1'b0;
    chk({digitalOffset, offsetDacCode}, {24'h01_7F80, 30'h2008_0200}, "digital");
    xfer(1'b1, 8'h30, 8'h9D);
    xfer(1'b1, 8'h5C, 8'h01);
    cyc(WAIT_CYC + 5);
    chk(autoBlackLevelCompOn, 0, "comp off");
    chk({offsetDacCode, offsetDacRangeQuarter}, {10'h206, 10'h3FD, 10'h003, 1'b1}, "dac");
  endtask
  task t_edges;
    sync(1'b0);
    chk(r * 2 + f, 1, "trailing one");
    sync(1'b1);
    chk(r * 2 + f, 0, "unselected");
    xfer(1'b1, 8'h4C, 8'h01);
    sync(1'b0);
    chk(r * 2 + f, 2, "leading one");
    lineSyncSelect <= 1'b1;
    sync(1'b1);
    chk(r * 2 + f, 1, "trailing two");
    xfer(1'b1, 8'h4C, 8'h03);
    sync(1'b1);
    chk(r * 2 + f, 2, "leading two");
    lineSyncSelect <= 1'b0;
  endtask
  task t_coast;
    xfer(1'b1, 8'h44, 8'h01);
    xfer(1'b1, 8'h48, 8'h02);
    frameSyncIn <= 1'b1;
    cyc(6);
    chk(pllCoast, 1, "frame coast");
    frameSyncIn <= 1'b0;
    repeat (4) begin
      cyc(1);
      chk(pllCoast, 1, "post hold");
    end
    sync(1'b0);
    chk({r, 31'h0, pllCoast}, {32'd0, 32'd1}, "post one");
    sync(1'b0);
    chk(pllCoast, 0, "post end");
    sync(1'b0);
    chk({r, 31'h0, pllCoast}, {32'd1, 32'd1}, "tracking then pre coast");
  endtask
  initial begin
    {nrst, psel, penable, pwrite, lineSyncSelect, frameSyncIn, clampIn, lineSyncInputOne, lineSyncInputTwo} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_total;
    t_bw;
    t_offset;
    t_edges;
    t_coast;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude;
  end
endmodule
